// ---- inc/lke_pkg.sv ----
// lke_pkg: constants for the legacy keyboard emulation control block.
// assumes: a single host-controller clock domain shared by every user of the package.
package lke_pkg;

	// ==========================================================
	// host i/o ports seen by the emulation decode
	localparam logic [7:0] IO_DATA_PORT = 8'h60;
	localparam logic [7:0] IO_CMD_PORT = 8'h64;
	localparam logic [7:0] A20_CMD_BYTE = 8'hD1;
	// bit of the byte written to the data port that carries the requested gate a20 level
	localparam int A20_DATA_BIT = 1;

	// ==========================================================
	// register select codes on the operational register port
	localparam logic [2:0] SEL_CONTROL = 3'h0;
	localparam logic [2:0] SEL_STATUS = 3'h1;
	localparam logic [2:0] SEL_INPUT = 3'h2;
	localparam logic [2:0] SEL_OUTPUT = 3'h3;
	localparam logic [2:0] SEL_ROUTING = 3'h4;

	// ==========================================================
	// emulation_control bit positions
	localparam int CTL_EMUL_ON = 0;
	localparam int CTL_EMUL_IRQ = 1;
	localparam int CTL_CHAR_WAITING = 2;
	localparam int CTL_LEGACY_GATE = 3;
	localparam int CTL_EXT_GATE = 4;
	localparam int CTL_A20_SEQ = 5;
	localparam int CTL_KBD_SEEN = 6;
	localparam int CTL_MOUSE_SEEN = 7;
	localparam int CTL_A20_STATE = 8;

	// ==========================================================
	// emulation_status bit positions
	localparam int STS_OUT_FULL = 0;
	localparam int STS_IN_FULL = 1;
	localparam int STS_CMD_OR_DATA = 3;
	localparam int STS_AUX_OUT_FULL = 5;

	// ==========================================================
	// routing field positions and reset values
	localparam int RT_EN_KBD = 0;
	localparam int RT_EN_MOUSE = 1;
	localparam int RT_BLK_KBD = 2;
	localparam int RT_BLK_MOUSE = 3;
	localparam logic [3:0] ROUTING_RESET = 4'h3;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

// ---- inc/lke_edge_if.sv ----
// lke_edge_if: carries one synchronised irq level and its rising-edge pulse.
// assumes: producer and consumer share clk_sys_i.
interface lke_edge_if;
	timeunit 1ns;
	timeprecision 1ps;
	logic level;
	logic rise;
	modport src (output level, output rise);
	modport dst (input level, input rise);
endinterface

// ---- rtl/lke_irq_edge.sv ----
// lke_irq_edge: two-stage synchroniser and rising-edge detector for one irq pin.
// assumes: the pin is asynchronous to clk_sys_i; reset is synchronous, active low.
module lke_irq_edge (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// raw pin
	input wire logic pin_i,
	// synchronised result
	lke_edge_if.src edge_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic meta_q;
	logic sync_q;
	logic last_q;

	// ==========================================================
	// synchroniser: meta_q is read only by sync_q
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= pin_i;
			sync_q <= meta_q;
		end
	end

	// ==========================================================
	// edge detect on the settled level
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			last_q <= 1'b0;
		end else begin
			last_q <= sync_q;
		end
	end

	assign edge_o.level = sync_q;
	assign edge_o.rise = sync_q & ~last_q;

endmodule

// ---- rtl/lke_ctrl.sv ----
// lke_ctrl: legacy keyboard and mouse emulation control and status.
// assumes: one host-controller clock; io and register strobes are one-cycle pulses
// from logic on the same clock; kbc irq pins are asynchronous.

// Notes on behaviour
// R01: emulation on enables port decode and irqs; here the decode, the input-full irq term and the kbc line pass-through depend on it
// R02: bit 1 is live decode, read-only
// R03: char waiting raises interrupt while output empty
// R04: legacy gate drives kbd or mouse irq
// R05: external irq gate raises interrupt on a seen kbc irq
// R06: D1h to command port starts a20 sequence
// R07: keyboard irq rise sets flag, write-1 clears
// R08: mouse irq rise sets flag, write-1 clears
// R09: a20 state compared with data port write
// R10: routing nibble resets to 3, enable/block bits
// R11: routing register only in first instance
// R12: data port read empties output buffer
// R13: port writes fill input buffer, except a20
// R14: data port clears, command port sets cmd flag
// R15: sync kbc irqs; interrupt ORs all conditions
// R16: control bits 31:9 read zero
module lke_ctrl #(
	parameter bit FIRST_INSTANCE = 1'b1
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// host i/o port access
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	input wire logic [7:0] io_addr_i,
	input wire logic [7:0] io_wdata_i,
	output logic io_claim_o,
	output logic [7:0] io_rdata_o,
	// operational register access by emulation software
	input wire logic reg_rd_i,
	input wire logic reg_wr_i,
	input wire logic [2:0] reg_sel_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	// external keyboard controller irqs
	input wire logic kbc_kbd_irq_i,
	input wire logic kbc_mouse_irq_i,
	// interrupt outputs
	output logic kbd_irq_o,
	output logic mouse_irq_o,
	output logic emul_irq_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// control state
	logic emul_on_q;
	logic char_waiting_q;
	logic legacy_irq_gate_q;
	logic ext_kbc_irq_gate_q;
	logic a20_cmd_seq_flag_q;
	logic kbd_irq_seen_q;
	logic mouse_irq_seen_q;
	logic a20_line_state_q;
	// status and data state
	logic [7:0] status_q;
	logic [7:0] in_data_q;
	logic [7:0] out_data_q;
	logic [3:0] routing_q;
	// decodes
	logic io_data_rd;
	logic io_data_wr;
	logic io_cmd_rd;
	logic io_cmd_wr;
	logic a20_match;
	logic in_full_set;
	logic out_full_clr;
	logic wr_ctl;
	logic wr_sts;
	logic wr_in;
	logic wr_out;
	logic emul_irq_condition;
	logic [31:0] ctl_word;
	logic kbd_src;
	logic mouse_src;

	lke_edge_if kbd_edge ();
	lke_edge_if mouse_edge ();

	// ==========================================================
	// kbc irq synchronisers
	lke_irq_edge u_kbd_edge (  // [R15]
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.pin_i(kbc_kbd_irq_i),
		.edge_o(kbd_edge)
	);

	lke_irq_edge u_mouse_edge (  // [R15]
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.pin_i(kbc_mouse_irq_i),
		.edge_o(mouse_edge)
	);

	// ==========================================================
	// host i/o decode, live only while emulation is on
	assign io_data_rd = emul_on_q & io_rd_i & (io_addr_i == lke_pkg::IO_DATA_PORT);  // [R01]
	assign io_cmd_rd = emul_on_q & io_rd_i & (io_addr_i == lke_pkg::IO_CMD_PORT);  // [R01]
	assign io_data_wr = emul_on_q & io_wr_i & (io_addr_i == lke_pkg::IO_DATA_PORT);  // [R01]
	assign io_cmd_wr = emul_on_q & io_wr_i & (io_addr_i == lke_pkg::IO_CMD_PORT);  // [R01]
	assign io_claim_o = io_data_rd | io_cmd_rd | io_data_wr | io_cmd_wr;

	// a data write that asks for the a20 level already present needs no software
	assign a20_match = (io_wdata_i[lke_pkg::A20_DATA_BIT] == a20_line_state_q);  // [R09]
	assign in_full_set = (io_cmd_wr & (io_wdata_i != lke_pkg::A20_CMD_BYTE))
		| (io_data_wr & ~(a20_cmd_seq_flag_q & a20_match));  // [R13]
	assign out_full_clr = io_data_rd;  // [R12]

	// ==========================================================
	// register write strobes
	assign wr_ctl = reg_wr_i & (reg_sel_i == lke_pkg::SEL_CONTROL);
	assign wr_sts = reg_wr_i & (reg_sel_i == lke_pkg::SEL_STATUS);
	assign wr_in = reg_wr_i & (reg_sel_i == lke_pkg::SEL_INPUT);
	assign wr_out = reg_wr_i & (reg_sel_i == lke_pkg::SEL_OUTPUT);

	// ==========================================================
	// emulation interrupt condition: pure decode, no storage
	assign emul_irq_condition =
		(char_waiting_q & ~status_q[lke_pkg::STS_OUT_FULL])  // [R03]
		| (emul_on_q & status_q[lke_pkg::STS_IN_FULL])  // [R13]
		| (ext_kbc_irq_gate_q & (kbd_irq_seen_q | mouse_irq_seen_q));  // [R05] [R15]

	// ==========================================================
	// software-owned control bits
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			emul_on_q <= 1'b0;
			char_waiting_q <= 1'b0;
			legacy_irq_gate_q <= 1'b0;
			ext_kbc_irq_gate_q <= 1'b0;
			a20_line_state_q <= 1'b0;
		end else if (wr_ctl) begin
			emul_on_q <= reg_wdata_i[lke_pkg::CTL_EMUL_ON];
			char_waiting_q <= reg_wdata_i[lke_pkg::CTL_CHAR_WAITING];
			legacy_irq_gate_q <= reg_wdata_i[lke_pkg::CTL_LEGACY_GATE];
			ext_kbc_irq_gate_q <= reg_wdata_i[lke_pkg::CTL_EXT_GATE];
			a20_line_state_q <= reg_wdata_i[lke_pkg::CTL_A20_STATE];
		end
	end

	// ==========================================================
	// a20 sequence flag: a command port write wins over a software write
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			a20_cmd_seq_flag_q <= 1'b0;
		end else if (io_cmd_wr) begin
			a20_cmd_seq_flag_q <= (io_wdata_i == lke_pkg::A20_CMD_BYTE);  // [R06]
		end else if (wr_ctl) begin
			a20_cmd_seq_flag_q <= reg_wdata_i[lke_pkg::CTL_A20_SEQ];
		end
	end

	// ==========================================================
	// irq-seen flags: a rise in the clearing cycle keeps the flag set
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			kbd_irq_seen_q <= 1'b0;
		end else if (kbd_edge.rise) begin
			kbd_irq_seen_q <= 1'b1;  // [R07]
		end else if (wr_ctl & reg_wdata_i[lke_pkg::CTL_KBD_SEEN]) begin
			kbd_irq_seen_q <= 1'b0;  // [R07]
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			mouse_irq_seen_q <= 1'b0;
		end else if (mouse_edge.rise) begin
			mouse_irq_seen_q <= 1'b1;  // [R08]
		end else if (wr_ctl & reg_wdata_i[lke_pkg::CTL_MOUSE_SEEN]) begin
			mouse_irq_seen_q <= 1'b0;  // [R08]
		end
	end

	// ==========================================================
	// status byte: software writes first, port side effects override, except a software 1 to output full beats a data port read
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			status_q <= lke_pkg::BYTE_RESET;
		end else begin
			if (wr_sts) begin
				status_q <= reg_wdata_i[7:0];
			end
			if (out_full_clr & ~(wr_sts & reg_wdata_i[lke_pkg::STS_OUT_FULL])) begin
				status_q[lke_pkg::STS_OUT_FULL] <= 1'b0;  // [R12]
			end
			if (in_full_set) begin
				status_q[lke_pkg::STS_IN_FULL] <= 1'b1;  // [R13]
			end
			if (io_data_wr) begin
				status_q[lke_pkg::STS_CMD_OR_DATA] <= 1'b0;  // [R14]
			end else if (io_cmd_wr) begin
				status_q[lke_pkg::STS_CMD_OR_DATA] <= 1'b1;  // [R14]
			end
		end
	end

	// ==========================================================
	// data bytes; port writes capture the byte, direct access has no side effect
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			in_data_q <= lke_pkg::BYTE_RESET;
		end else if (io_data_wr | io_cmd_wr) begin
			in_data_q <= io_wdata_i;  // [R01]
		end else if (wr_in) begin
			in_data_q <= reg_wdata_i[7:0];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			out_data_q <= lke_pkg::BYTE_RESET;
		end else if (wr_out) begin
			out_data_q <= reg_wdata_i[7:0];
		end
	end

	// ==========================================================
	// legacy routing; later instances keep the fixed reset value
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			routing_q <= lke_pkg::ROUTING_RESET;  // [R10]
		end else if (FIRST_INSTANCE && reg_wr_i && (reg_sel_i == lke_pkg::SEL_ROUTING)) begin
			routing_q <= reg_wdata_i[3:0];  // [R11]
		end
	end

	// emulated irq in every mode; while emulation is off the real kbc line is ORed in
	always_comb begin
		kbd_src = legacy_irq_gate_q & status_q[lke_pkg::STS_OUT_FULL]
			& ~status_q[lke_pkg::STS_AUX_OUT_FULL];  // [R04]
		mouse_src = legacy_irq_gate_q & status_q[lke_pkg::STS_OUT_FULL]
			& status_q[lke_pkg::STS_AUX_OUT_FULL];  // [R04]
		if (!emul_on_q) begin
			kbd_src = kbd_src | kbd_edge.level;
			mouse_src = mouse_src | mouse_edge.level;
		end
	end

	// ==========================================================
	// registered interrupt outputs
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			kbd_irq_o <= 1'b0;
			mouse_irq_o <= 1'b0;
			emul_irq_o <= 1'b0;
		end else begin
			kbd_irq_o <= kbd_src & routing_q[lke_pkg::RT_EN_KBD]
				& ~routing_q[lke_pkg::RT_BLK_KBD];  // [R10]
			mouse_irq_o <= mouse_src & routing_q[lke_pkg::RT_EN_MOUSE]
				& ~routing_q[lke_pkg::RT_BLK_MOUSE];  // [R10]
			emul_irq_o <= emul_irq_condition;  // [R15]
		end
	end

	// ==========================================================
	// control word as read back; upper bits tie to zero
	always_comb begin
		ctl_word = lke_pkg::WORD_ZERO;  // [R16]
		ctl_word[lke_pkg::CTL_EMUL_ON] = emul_on_q;
		ctl_word[lke_pkg::CTL_EMUL_IRQ] = emul_irq_condition;  // [R02]
		ctl_word[lke_pkg::CTL_CHAR_WAITING] = char_waiting_q;
		ctl_word[lke_pkg::CTL_LEGACY_GATE] = legacy_irq_gate_q;
		ctl_word[lke_pkg::CTL_EXT_GATE] = ext_kbc_irq_gate_q;
		ctl_word[lke_pkg::CTL_A20_SEQ] = a20_cmd_seq_flag_q;
		ctl_word[lke_pkg::CTL_KBD_SEEN] = kbd_irq_seen_q;
		ctl_word[lke_pkg::CTL_MOUSE_SEEN] = mouse_irq_seen_q;
		ctl_word[lke_pkg::CTL_A20_STATE] = a20_line_state_q;  // [R09]
	end

	// ==========================================================
	// read data, one cycle after the strobe; routing is write-only
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= lke_pkg::WORD_ZERO;
		end else if (reg_rd_i) begin
			unique case (reg_sel_i)
				lke_pkg::SEL_CONTROL: reg_rdata_o <= ctl_word;
				lke_pkg::SEL_STATUS: reg_rdata_o <= {24'h00_0000, status_q};
				lke_pkg::SEL_INPUT: reg_rdata_o <= {24'h00_0000, in_data_q};
				lke_pkg::SEL_OUTPUT: reg_rdata_o <= {24'h00_0000, out_data_q};
				default: reg_rdata_o <= lke_pkg::WORD_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			io_rdata_o <= lke_pkg::BYTE_RESET;
		end else if (io_data_rd) begin
			io_rdata_o <= out_data_q;  // [R12]
		end else if (io_cmd_rd) begin
			io_rdata_o <= status_q;  // [R01]
		end
	end

endmodule

// ---- test/lke_ctrl_checker.sv ----
// lke_ctrl_checker: port assertions for lke_ctrl.
// assumes: bound to every lke_ctrl; the bench leaves one idle cycle between accesses.
module lke_ctrl_checker (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// host i/o
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	input wire logic [7:0] io_addr_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic io_claim_o,
	// register port and irq
	input wire logic reg_rd_i,
	input wire logic reg_wr_i,
	input wire logic [2:0] reg_sel_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic emul_irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!nrst_i);
	// ==========================================================
	// claimed port access, then a register read two cycles on
	sequence port_op(logic rd, logic [7:0] p);
		io_claim_o && io_rd_i == rd && io_addr_i == p;
	endsequence
	sequence rd_reg(logic [2:0] s);
		reg_rd_i && !reg_wr_i && reg_sel_i == s;
	endsequence
	sequence cmd_wr;
		port_op(1'b0, lke_pkg::IO_CMD_PORT) ##0 io_wdata_i != lke_pkg::A20_CMD_BYTE;
	endsequence
	claim_addr_a: assert property (io_claim_o |-> (io_rd_i || io_wr_i) &&
		(io_addr_i == lke_pkg::IO_DATA_PORT || io_addr_i == lke_pkg::IO_CMD_PORT))
		else $error("claim outside the data and command ports");
	data_flag_a: assert property (port_op(1'b0, lke_pkg::IO_DATA_PORT) ##2
		rd_reg(lke_pkg::SEL_STATUS) |=> !reg_rdata_o[lke_pkg::STS_CMD_OR_DATA])
		else $error("command flag set after data port write");
	cmd_flag_a: assert property (port_op(1'b0, lke_pkg::IO_CMD_PORT) ##2
		rd_reg(lke_pkg::SEL_STATUS) |=> reg_rdata_o[lke_pkg::STS_CMD_OR_DATA])
		else $error("command flag clear after command port write");
	in_full_a: assert property (cmd_wr ##2 rd_reg(lke_pkg::SEL_STATUS) |=>
		reg_rdata_o[lke_pkg::STS_IN_FULL]) else $error("input full not set");
	out_empty_a: assert property (port_op(1'b1, lke_pkg::IO_DATA_PORT) ##2
		rd_reg(lke_pkg::SEL_STATUS) |=> !reg_rdata_o[lke_pkg::STS_OUT_FULL])
		else $error("output full kept after data port read");
	emul_cond_a: assert property (cmd_wr ##1 !reg_wr_i |=> emul_irq_o)
		else $error("no emulation interrupt with input full");
	live_bit_a: assert property (rd_reg(lke_pkg::SEL_CONTROL) |=>
		reg_rdata_o[lke_pkg::CTL_EMUL_IRQ] == emul_irq_o) else $error("live bit differs");
	ctl_resv_a: assert property (rd_reg(lke_pkg::SEL_CONTROL) |=>
		reg_rdata_o[31:9] == 23'h0) else $error("reserved control bits not zero");
	unmapped_a: assert property (reg_rd_i && reg_sel_i >= lke_pkg::SEL_ROUTING |=>
		reg_rdata_o == 32'h0000_0000) else $error("unreadable select returned data");
endmodule

bind lke_ctrl lke_ctrl_checker u_chk (.*);

// ---- test/lke_host_model.sv ----
// lke_host_model: host i/o master and keyboard controller irq pins.
// assumes: strobes change at the falling edge and last one cycle.
module lke_host_model (
	// clock
	input wire logic clk_sys_i,
	// host i/o
	output logic io_rd_o,
	output logic io_wr_o,
	output logic [7:0] io_addr_o,
	output logic [7:0] io_wdata_o,
	// keyboard controller irqs
	output logic kbd_pin_o,
	output logic mouse_pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{io_rd_o, io_wr_o, kbd_pin_o, mouse_pin_o} = 4'h0;
		io_addr_o = 8'h00;
		io_wdata_o = 8'h00;
	end
	// released bus shows inverted values so stale data cannot pass
	task automatic io(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		io_wr_o = wr;
		io_rd_o = !wr;
		io_addr_o = a;
		io_wdata_o = d;
		@(negedge clk_sys_i);
		{io_rd_o, io_wr_o} = 2'h0;
		io_addr_o = ~a;
		io_wdata_o = ~d;
	endtask
	task automatic pin(input logic mouse, input logic v);
		@(negedge clk_sys_i);
		if (mouse) mouse_pin_o = v;
		else kbd_pin_o = v;
	endtask
endmodule

// ---- test/tb.sv ----
// tb: self-checking bench for lke_ctrl.
// assumes: the host model drives io and kbc pins; the bench drives registers.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int op; logic [7:0] a; logic [11:0] d; logic [2:0] rs; logic [11:0] ex;} lke_row_t;
	logic clk_sys_i, nrst_i, io_rd_i, io_wr_i, io_claim_o, reg_rd_i, reg_wr_i;
	logic [7:0] io_addr_i, io_wdata_i, io_rdata_o;
	logic [2:0] reg_sel_i;
	logic [31:0] reg_wdata_i, reg_rdata_o;
	logic kbc_kbd_irq_i, kbc_mouse_irq_i, kbd_irq_o, mouse_irq_o, emul_irq_o, kbd_irq_b;
	int fail_count = 0;
	int n_compared = 0;
	int n_claims = 0;
	// count claimed port accesses so a dead decode cannot hide behind vacuous assertions
	always @(posedge clk_sys_i) begin
		if (io_claim_o) n_claims++;
	end
	// op 0 register write, 1 port write, 2 port read; then read register rs
	lke_row_t rows[17] = '{'{0, 8'h00, 12'h001, 3'h0, 12'h001}, '{0, 8'h03, 12'h0A5, 3'h3, 12'h0A5},
		'{0, 8'h01, 12'h021, 3'h1, 12'h021}, '{2, 8'h60, 12'h000, 3'h1, 12'h020},
		'{1, 8'h60, 12'h05A, 3'h1, 12'h022}, '{1, 8'h64, 12'h042, 3'h1, 12'h02A},
		'{0, 8'h01, 12'h000, 3'h2, 12'h042}, '{1, 8'h64, 12'h0D1, 3'h0, 12'h021},
		'{1, 8'h60, 12'h002, 3'h1, 12'h002}, '{0, 8'h01, 12'h000, 3'h1, 12'h000},
		'{1, 8'h60, 12'h000, 3'h1, 12'h000}, '{1, 8'h64, 12'h042, 3'h0, 12'h003},
		'{0, 8'h00, 12'h004, 3'h0, 12'h006}, '{0, 8'h01, 12'h001, 3'h0, 12'h004},
		'{1, 8'h64, 12'h011, 3'h2, 12'h042}, '{0, 8'h00, 12'hFFF, 3'h0, 12'h13D},
		'{0, 8'h00, 12'h000, 3'h0, 12'h000}};
	lke_ctrl dut (.*);
	lke_ctrl #(.FIRST_INSTANCE(1'b0)) dut_b (.*, .io_claim_o(), .io_rdata_o(), .reg_rdata_o(),
		.kbd_irq_o(kbd_irq_b), .mouse_irq_o(), .emul_irq_o());
	lke_host_model host (.clk_sys_i(clk_sys_i), .io_rd_o(io_rd_i), .io_wr_o(io_wr_i),
		.io_addr_o(io_addr_i), .io_wdata_o(io_wdata_i), .kbd_pin_o(kbc_kbd_irq_i),
		.mouse_pin_o(kbc_mouse_irq_i));
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rw(input logic wr, input logic [2:0] s, input logic [31:0] d);
		@(negedge clk_sys_i);
		reg_wr_i = wr;
		reg_rd_i = !wr;
		reg_sel_i = s;
		reg_wdata_i = d;
		@(negedge clk_sys_i);
		{reg_rd_i, reg_wr_i} = 2'h0;
	endtask
	task automatic rchk(input string nm, input logic [2:0] s, input logic [31:0] e);
		rw(1'b0, s, 32'h0000_0000);
		chk(nm, e, reg_rdata_o);
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#100us;
		fail_count++;
		report_and_stop();
	end
	initial begin
		logic [31:0] e;
		{nrst_i, reg_rd_i, reg_wr_i, reg_sel_i, reg_wdata_i} = '0;
		repeat (4) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		for (int s = 0; s < 5; s++) rchk("reset_reg", 3'(s), 32'h0000_0000);
		chk("reset_irqs", 32'h0000_0000, 32'({kbd_irq_o, mouse_irq_o, emul_irq_o}));
		$display("test reset done");
		foreach (rows[i]) begin
			if (rows[i].op == 0) rw(1'b1, rows[i].a[2:0], 32'(rows[i].d));
			else host.io(rows[i].op == 1, rows[i].a, rows[i].d[7:0]);
			rchk("row", rows[i].rs, 32'(rows[i].ex));
		end
		$display("test table done");
		rw(1'b1, lke_pkg::SEL_CONTROL, 32'h0000_0008);
		for (int x = 0; x < 32; x++) begin
			rw(1'b1, lke_pkg::SEL_STATUS, {26'h0, x[4], 5'h01});
			rw(1'b1, lke_pkg::SEL_ROUTING, {28'h0, x[3:0]});
			repeat (2) @(negedge clk_sys_i);
			chk("kbd_irq", 32'(!x[4] && x[0] && !x[2]), 32'(kbd_irq_o));
			chk("mouse_irq", 32'(x[4] && x[1] && !x[3]), 32'(mouse_irq_o));
			chk("kbd_irq_b", 32'(!x[4]), 32'(kbd_irq_b));
		end
		// mid-run reset must bring routing back to its default
		@(negedge clk_sys_i);
		nrst_i = 1'b0;
		repeat (3) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		rw(1'b1, lke_pkg::SEL_STATUS, 32'h0000_0001);
		rw(1'b1, lke_pkg::SEL_CONTROL, 32'h0000_0008);
		repeat (2) @(negedge clk_sys_i);
		chk("kbd_irq_dflt", 32'h0000_0001, 32'(kbd_irq_o));
		$display("test routing done");
		rw(1'b1, lke_pkg::SEL_CONTROL, 32'h0000_0010);
		for (int i = 0; i < 2; i++) begin
			e = 32'h0000_0040 << i;
			host.pin(i[0], 1'b1);
			repeat (5) @(negedge clk_sys_i);
			chk("emul_irq", 32'h0000_0001, 32'(emul_irq_o));
			rchk("seen_set", lke_pkg::SEL_CONTROL, e | 32'h0000_0012);
			rw(1'b1, lke_pkg::SEL_CONTROL, 32'h0000_0010);
			rchk("seen_keep", lke_pkg::SEL_CONTROL, e | 32'h0000_0012);
			rw(1'b1, lke_pkg::SEL_CONTROL, e | 32'h0000_0010);
			rchk("seen_clr", lke_pkg::SEL_CONTROL, 32'h0000_0010);
			host.pin(i[0], 1'b0);
		end
		// rise and write-1 clear meet at one edge: the set must win
		host.pin(1'b0, 1'b1);
		@(negedge clk_sys_i);
		rw(1'b1, lke_pkg::SEL_CONTROL, 32'h0000_0050);
		rchk("seen_race", lke_pkg::SEL_CONTROL, 32'h0000_0052);
		host.pin(1'b0, 1'b0);
		$display("test kbc done");
		rw(1'b1, lke_pkg::SEL_CONTROL, 32'h0000_0001);
		rw(1'b1, lke_pkg::SEL_OUTPUT, 32'h0000_0077);
		rw(1'b1, lke_pkg::SEL_STATUS, 32'h0000_0021);
		host.io(1'b0, lke_pkg::IO_CMD_PORT, 8'h00);
		chk("sts_byte", 32'h0000_0021, 32'(io_rdata_o));
		host.io(1'b0, lke_pkg::IO_DATA_PORT, 8'h00);
		chk("out_byte", 32'h0000_0077, 32'(io_rdata_o));
		rchk("sts_after", lke_pkg::SEL_STATUS, 32'h0000_0020);
		chk("claims", 32'h0000_0009, 32'(n_claims));
		$display("test port read done");
		report_and_stop();
	end
endmodule
